// ---- core/i2cs_consts.svh ----
/*
 * Named constants for the two-wire slave receiver.
 * Assumes it is included by bare name from design files only.
 */
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH

// Byte framing
`define I2CS_BYTE_W 8
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_CNT_ZERO 4'h0
`define I2CS_CNT_ONE 4'h1
`define I2CS_RW_BIT 0

// Long address first byte pattern and upper address bit field
`define I2CS_HI_PATTERN 5'h1e
`define I2CS_HI_A9_BIT 2
`define I2CS_HI_A8_BIT 1

// Reset values and general call address
`define I2CS_MASK_RST 8'hff
`define I2CS_ADDR_RST 8'h00
`define I2CS_GCALL_ADDR 8'h00

// Mode select bit positions
`define I2CS_MODE_LONG_BIT 0
`define I2CS_MODE_EVENT_BIT 1

// Receive buffer shape
`define I2CS_FIFO_DEPTH 16

`endif

// ---- core/i2cs_pkg.sv ----
/*
 * Types shared by the two-wire slave receiver.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package i2cs_pkg;

    // Receive sequencer states
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_alow = 3'b010,
        st_data = 3'b011,
        st_ack = 3'b100
    } i2cs_state_t;

endpackage

// ---- core/i2cs_sync.sv ----
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes inputs are asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module i2cs_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_q; // First stage, read only by second

    // Both stages idle high, like a released open-drain line
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= '1;
            pin_sync <= '1;
        end else if (clk_en) begin
            meta_q <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule

// ---- core/i2cs_fifo.sv ----
/*
 * Receive buffer: flip-flop FIFO with a registered output stage.
 * Assumes a single clock; the drain side may stall at any time.
 */
`timescale 1ns/1ps
module i2cs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH]; // Storage entries
    logic [AW-1:0] wr_q; // Write index
    logic [AW-1:0] rd_q; // Read index
    logic [AW:0] cnt_q; // Entries held in storage
    logic push;
    logic load;

    // Output stage takes a word whenever it is empty or being drained
    assign in_ready = (cnt_q != FULL_CNT);
    assign push = in_valid && in_ready;
    assign load = (cnt_q != '0) && (!out_valid || out_ready);

    // One write enable per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_sys) begin
            if (clk_en && push && (wr_q == AW'(i))) begin
                mem_q[i] <= in_data;
            end
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_q <= AW'(wr_q + 1'b1);
            end
            if (load) begin
                rd_q <= AW'(rd_q + 1'b1);
            end
            cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load});
        end
    end

    // Registered output word
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (clk_en) begin
            if (load) begin
                out_valid <= 1'b1;
                out_data <= mem_q[rd_q];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// ---- core/i2cs_slave.sv ----
/*
 * Two-wire slave receiver: own-address match,
 * events, update handshake, reception, stretch.
 * Assumes control ports on clk_sys and
 * resolved open-drain levels on the line inputs.
 * No transmit path.
 */
`timescale 1ns/1ps
`include "i2cs_consts.svh"

// Notes on behaviour
// - Four modes: short/long address, events optional
// - Event modes also flag start, restart, stop
// - Matching first byte buffered and raises interrupt
// - Mismatch goes idle with no flag
// - Short mode ignores direction bit in compare
// - Long high byte compared to 11110,A9,A8,0
// - High match sets update flag, holds clock
// - Low byte always flags and holds clock
// - Own-address write clears update flag
// - Long read needs prior full write match
// - Write address clears direction, buffered, acknowledged
// - Overflow NACKs address unless override enabled
// - Interrupt flag per byte, sticky until cleared
// - Stretch enable holds clock until release bit
// - Start sets start-seen, interrupt if enabled
// - Reading buffer clears buffer-full flag
// - Each data byte acknowledged and flagged unless overflow blocks it
// - Stop sets stop-seen, bus goes idle
// - Mask zeros make address bits don't-care, except A9,A8 in the long high byte
// - Mask resets to all ones
// - General call acknowledged when enabled
module i2cs_slave
    import i2cs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] port_mode_select,
    input wire logic general_call_enable,
    input wire logic stretch_enable,
    input wire logic buffer_override_enable,
    input wire logic own_address_wr,
    input wire logic [7:0] own_address_wdata,
    input wire logic address_mask_wr,
    input wire logic [7:0] address_mask_wdata,
    input wire logic clock_release_set,
    input wire logic serial_irq_clear,
    input wire logic overflow_clear,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic [7:0] own_address_reg,
    output logic serial_irq_flag,
    output logic address_update_flag,
    output logic buffer_full_flag,
    output logic receive_overflow_flag,
    output logic start_seen,
    output logic stop_seen,
    output logic direction_bit,
    output logic clock_release_bit
);
    logic scl_s; // Synchronised clock line
    logic sda_s; // Synchronised data line
    logic scl_p_q; // Previous synchronised levels
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    i2cs_state_t state_q; // Receive sequencer
    i2cs_state_t next_q; // State to enter after the ACK slot
    logic [3:0] cnt_q; // Bits sampled in current byte
    logic [7:0] shift_register; // Incoming bits, MSB first
    logic [7:0] address_mask_reg; // Mask, zero bit is don't-care
    logic full_match_q; // Long address fully matched as write
    logic ua_pend_q; // Update flag due at end of ACK slot
    logic hold_q; // Clock stretch in force
    logic fifo_in_ready;
    logic push_q; // One-cycle write into receive buffer
    logic [7:0] push_data_q;
    // Decision terms at the eighth and ninth falling edges, and clock release
    logic byte_done;
    logic ninth_fall;
    logic long_mode;
    logic event_mode;
    logic blocked;
    logic hit7;
    logic hi_hit;
    logic low_hit;
    logic gcall;
    logic do_ack;
    logic do_push;
    logic do_irq;
    logic ua_now;
    logic ua_later;
    logic ovf_set;
    logic dir_load;
    i2cs_state_t after_ack;
    logic release_now;

    // Pin inputs cross two flip-flops before use
    i2cs_sync #(.WIDTH(2)) u_sync (
        .clk_sys(clk_sys),
        .clk_en(clk_en),
        .srst(srst),
        .pin_in({scl_in, sda_in}),
        .pin_sync({scl_s, sda_s})
    );

    // Edge history of the synchronised lines
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (clk_en) begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    // Data changes while the clock line stays high mark bus conditions
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

    assign long_mode = port_mode_select[`I2CS_MODE_LONG_BIT];
    assign event_mode = port_mode_select[`I2CS_MODE_EVENT_BIT];
    assign byte_done = scl_fall && (cnt_q == `I2CS_BITS_PER_BYTE) &&
                       (state_q == st_addr || state_q == st_alow || state_q == st_data);
    assign ninth_fall = scl_fall && (state_q == st_ack);
    // Override acks despite a pending overflow
    assign blocked = (buffer_full_flag || receive_overflow_flag) && !buffer_override_enable;

    // Address comparators
    assign hit7 = ((shift_register[7:1] ^ own_address_reg[7:1]) & address_mask_reg[7:1]) == 7'h00;
    assign hi_hit = shift_register[7:1] == {`I2CS_HI_PATTERN, own_address_reg[`I2CS_HI_A9_BIT],
                                            own_address_reg[`I2CS_HI_A8_BIT]};
    assign low_hit = ((shift_register ^ own_address_reg) & address_mask_reg) == 8'h00;
    assign gcall = general_call_enable && (shift_register == `I2CS_GCALL_ADDR);

    // Per-byte decision taken on the falling edge after bit eight
    always_comb begin
        do_ack = 1'b0;
        do_push = 1'b0;
        do_irq = 1'b0;
        ua_now = 1'b0;
        ua_later = 1'b0;
        ovf_set = 1'b0;
        dir_load = 1'b0;
        after_ack = st_idle;
        if (byte_done) begin
            case (state_q)
                st_addr: begin
                    if (gcall) begin
                        // General call is plain data afterwards, no update flag
                        do_ack = !blocked;
                        after_ack = st_data;
                    end else if (long_mode && hi_hit && !shift_register[`I2CS_RW_BIT]) begin
                        do_ack = !blocked;
                        ua_later = !blocked;
                        after_ack = st_alow;
                    end else if (long_mode && hi_hit && full_match_q) begin
                        // Read request only after a full write match
                        do_ack = !blocked;
                        after_ack = st_idle;
                    end else if (!long_mode && hit7) begin
                        do_ack = !blocked;
                        after_ack = shift_register[`I2CS_RW_BIT] ? st_idle : st_data;
                    end
                    // A matched address that is refused counts as overflow
                    if ((gcall || (long_mode && hi_hit) || (!long_mode && hit7)) && blocked) begin
                        ovf_set = buffer_full_flag;
                    end
                    dir_load = do_ack;
                end
                st_alow: begin
                    do_ack = low_hit && !blocked;
                    do_irq = 1'b1;
                    ua_later = do_ack;
                    ua_now = !do_ack;
                    after_ack = st_data;
                end
                st_data: begin
                    do_ack = !blocked;
                    ovf_set = blocked && buffer_full_flag;
                    after_ack = st_data;
                end
                default: begin
                    do_ack = 1'b0;
                end
            endcase
            do_push = do_ack;
            do_irq = do_irq || do_ack;
        end
    end

    // Sequencer, bit counter and shift register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= st_idle;
            next_q <= st_idle;
            cnt_q <= `I2CS_CNT_ZERO;
            shift_register <= 8'h00;
        end else if (clk_en) begin
            if (stop_det) begin
                state_q <= st_idle;
            end else if (start_det) begin
                // Start and restart both begin an address byte
                state_q <= st_addr;
                cnt_q <= `I2CS_CNT_ZERO;
            end else if (scl_rise && state_q != st_idle && state_q != st_ack) begin
                shift_register <= {shift_register[6:0], sda_s};
                cnt_q <= 4'(cnt_q + `I2CS_CNT_ONE);
            end else if (byte_done) begin
                // Refused or unmatched: idle
                state_q <= do_ack ? st_ack : st_idle;
                next_q <= after_ack;
            end else if (ninth_fall) begin
                state_q <= next_q;
                cnt_q <= `I2CS_CNT_ZERO;
            end
        end
    end

    // Data line pull-down during the ACK slot only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
        end else if (clk_en) begin
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            if (stop_det || start_det || ninth_fall) begin
                sda_oe <= 1'b0;
            end else if (byte_done && do_ack) begin
                sda_oe <= 1'b1;
            end
        end
    end

    // Stretch after the ACK slot until both reasons clear
    assign release_now = hold_q && !address_update_flag && clock_release_bit;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hold_q <= 1'b0;
            scl_oe <= 1'b0;
        end else if (clk_en) begin
            if ((ninth_fall && (ua_pend_q || stretch_enable)) || ua_now) begin
                hold_q <= 1'b1;
                scl_oe <= 1'b1;
            end else if (release_now) begin
                hold_q <= 1'b0;
                scl_oe <= 1'b0;
            end
        end
    end

    // Release bit: cleared by a stretch_enable stretch at the end of the ACK slot, set by software; set wins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clock_release_bit <= 1'b1;
        end else if (clk_en) begin
            if (clock_release_set) begin
                clock_release_bit <= 1'b1;
            end else if (ninth_fall && stretch_enable) begin
                clock_release_bit <= 1'b0;
            end
        end
    end

    // Own address and mask registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            own_address_reg <= `I2CS_ADDR_RST;
            address_mask_reg <= `I2CS_MASK_RST;
        end else if (clk_en) begin
            if (own_address_wr) begin
                own_address_reg <= own_address_wdata;
            end
            if (address_mask_wr) begin
                address_mask_reg <= address_mask_wdata;
            end
        end
    end

    // Address update flag; a hardware set beats a same-cycle write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ua_pend_q <= 1'b0;
            address_update_flag <= 1'b0;
        end else if (clk_en) begin
            if (byte_done) begin
                ua_pend_q <= ua_later;
            end else if (ninth_fall) begin
                ua_pend_q <= 1'b0;
            end
            if ((ninth_fall && ua_pend_q) || ua_now) begin
                address_update_flag <= 1'b1;
            end else if (own_address_wr) begin
                address_update_flag <= 1'b0;
            end
        end
    end

    // Full long-address match survives restarts, ends at stop
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            full_match_q <= 1'b0;
        end else if (clk_en) begin
            if (stop_det) begin
                full_match_q <= 1'b0;
            end else if (byte_done && state_q == st_alow && do_ack) begin
                full_match_q <= 1'b1;
            end
        end
    end

    // Status: direction, start, stop
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            direction_bit <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else if (clk_en) begin
            if (dir_load) begin
                direction_bit <= shift_register[`I2CS_RW_BIT];
            end
            if (start_det) begin
                start_seen <= 1'b1;
                stop_seen <= 1'b0;
            end else if (stop_det) begin
                start_seen <= 1'b0;
                stop_seen <= 1'b1;
            end
        end
    end

    // Interrupt flag: sticky, set wins over software clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            serial_irq_flag <= 1'b0;
        end else if (clk_en) begin
            if (do_irq || (event_mode && (start_det || stop_det))) begin
                serial_irq_flag <= 1'b1;
            end else if (serial_irq_clear) begin
                serial_irq_flag <= 1'b0;
            end
        end
    end

    // Overflow and buffer-full flags
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            receive_overflow_flag <= 1'b0;
            buffer_full_flag <= 1'b0;
        end else if (clk_en) begin
            if (ovf_set || (push_q && !fifo_in_ready)) begin
                receive_overflow_flag <= 1'b1;
            end else if (overflow_clear) begin
                receive_overflow_flag <= 1'b0;
            end
            // Draining a word makes room, which clears the full flag
            buffer_full_flag <= !fifo_in_ready;
        end
    end

    // Byte handed to the receive buffer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            push_q <= 1'b0;
            push_data_q <= 8'h00;
        end else if (clk_en) begin
            push_q <= do_push;
            push_data_q <= shift_register;
        end
    end

    i2cs_fifo #(.WIDTH(`I2CS_BYTE_W), .DEPTH(`I2CS_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .clk_en(clk_en),
        .srst(srst),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data_q),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_stop_idle: assert property (clk_en && stop_det |=> state_q == st_idle && stop_seen)
        else $error("stop did not idle the bus");
    a_start_flag: assert property (clk_en && start_det |=> start_seen && state_q == st_addr)
        else $error("start not recorded");
    a_nomatch_quiet: assert property (clk_en && byte_done && state_q == st_addr && !do_ack
        |=> state_q == st_idle && !$rose(serial_irq_flag) && !sda_oe)
        else $error("unmatched address left a trace");
    a_data_ack: assert property (clk_en && byte_done && state_q == st_data && !blocked
        |=> sda_oe && serial_irq_flag)
        else $error("data byte not acknowledged");
    a_ovf_nack: assert property (clk_en && byte_done && blocked |=> !sda_oe)
        else $error("acknowledged while overflowed");
    a_irq_sticky: assert property (clk_en && serial_irq_flag && !serial_irq_clear |=> serial_irq_flag)
        else $error("interrupt flag dropped by itself");
    a_ua_clear: assert property (clk_en && own_address_wr && !ua_now && !(ninth_fall && ua_pend_q)
        |=> !address_update_flag)
        else $error("address write left update flag set");
    a_ua_hold: assert property (clk_en && address_update_flag && hold_q |=> scl_oe)
        else $error("clock released before address update");
    a_stretch_hold: assert property (clk_en && ninth_fall && stretch_enable
        |=> scl_oe ##1 (scl_oe || clock_release_bit))
        else $error("stretch not applied");
    a_mask_reset: assert property ($fell(srst) |-> address_mask_reg == `I2CS_MASK_RST)
        else $error("mask not all ones after reset");
endmodule

// ---- dv/i2cs_master_model.sv ----
/*
 * Bus master model: start, stop and byte writes.
 * Assumes the bench resolves both lines with pull-ups.
 */
`timescale 1ns/1ps
module i2cs_master_model #(
    parameter int HALF = 10
) (
    input wire logic clk_sys,
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    // Released at time zero so both lines idle high
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Release the clock and honour any stretch by the slave
    task automatic rise();
        scl_oe = 1'b0;
        while (!scl) @(negedge clk_sys);
        hold(HALF);
    endtask
    // Start and stop move data while the clock is high
    task automatic start();
        hold(2);
        sda_oe = 1'b0;
        hold(HALF);
        rise();
        sda_oe = 1'b1;
        hold(HALF);
        scl_oe = 1'b1;
    endtask
    task automatic stop();
        hold(2);
        sda_oe = 1'b1;
        hold(HALF);
        rise();
        sda_oe = 1'b0;
        hold(HALF);
    endtask
    // Bytes go out most significant bit first; ack sampled at the end of the high phase
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            hold(2);
            sda_oe = (i > 0) ? ~b[i-1] : 1'b0;
            hold(HALF);
            rise();
            ack = ~sda;
            scl_oe = 1'b1;
        end
    endtask
endmodule

// ---- dv/i2c_slave_address_receive_test.sv ----
/*
 * Bench for the slave receiver: address rows, then hand-written cases.
 * Assumes the master model is compiled alongside.
 */
`timescale 1ns/1ps
module i2c_slave_address_receive_test;
    import i2cs_pkg::*;
    typedef struct packed {
        logic [7:0] own;
        logic [7:0] mask;
        logic gce;
        logic [7:0] b;
        logic ack;
    } i2cs_row_t;
    // Own, mask, general call, byte, ack expected
    i2cs_row_t rows [6] = '{'{8'ha2, 8'hff, 1'b0, 8'ha0, 1'b0}, '{8'ha0, 8'hff, 1'b0, 8'ha0, 1'b1},
        '{8'ha0, 8'hff, 1'b0, 8'ha1, 1'b1}, '{8'ha0, 8'hf9, 1'b0, 8'ha6, 1'b1},
        '{8'ha0, 8'hff, 1'b1, 8'h00, 1'b1}, '{8'ha0, 8'hff, 1'b0, 8'h00, 1'b0}};
    logic clk_sys, srst, m_scl_oe, m_sda_oe, scl_out, scl_oe, sda_out, sda_oe, ack;
    logic [1:0] port_mode_select;
    logic general_call_enable, stretch_enable, own_address_wr, address_mask_wr, clock_release_set;
    logic serial_irq_clear, overflow_clear, rx_ready, rx_valid, serial_irq_flag, address_update_flag;
    logic buffer_full_flag, receive_overflow_flag, start_seen, stop_seen, direction_bit, clock_release_bit;
    logic [7:0] own_address_wdata, address_mask_wdata, rx_data, own_address_reg;
    int err_total = 0;
    int total_checks = 0;
    // Open-drain lines: low if any party pulls
    wire scl_ln = !m_scl_oe & (scl_oe ? scl_out : 1'b1);
    wire sda_ln = !m_sda_oe & (sda_oe ? sda_out : 1'b1);
    i2cs_master_model i2cs_master_model_i (.clk_sys(clk_sys), .scl(scl_ln), .sda(sda_ln),
        .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
    i2cs_slave i2cs_slave_i (.clk_sys(clk_sys), .clk_en(1'b1), .srst(srst), .scl_in(scl_ln), .sda_in(sda_ln),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .port_mode_select(port_mode_select), .general_call_enable(general_call_enable),
        .stretch_enable(stretch_enable), .buffer_override_enable(1'b0), .own_address_wr(own_address_wr),
        .own_address_wdata(own_address_wdata), .address_mask_wr(address_mask_wr),
        .address_mask_wdata(address_mask_wdata), .clock_release_set(clock_release_set),
        .serial_irq_clear(serial_irq_clear), .overflow_clear(overflow_clear), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .own_address_reg(own_address_reg),
        .serial_irq_flag(serial_irq_flag), .address_update_flag(address_update_flag),
        .buffer_full_flag(buffer_full_flag), .receive_overflow_flag(receive_overflow_flag),
        .start_seen(start_seen), .stop_seen(stop_seen), .direction_bit(direction_bit),
        .clock_release_bit(clock_release_bit));
    // 8 ns system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One-cycle control pulse launched off the falling edge
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic own(input logic [7:0] v);
        own_address_wdata = v;
        pulse(own_address_wr);
    endtask
    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Cut a hang short
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        test_done();
    end
    initial begin
        {port_mode_select, general_call_enable, stretch_enable, own_address_wr, address_mask_wr} = '0;
        {clock_release_set, serial_irq_clear, overflow_clear, rx_ready} = '0;
        {own_address_wdata, address_mask_wdata} = '0;
        srst = 1'b1;
        hold(20);
        srst = 1'b0;
        chk({clock_release_bit, serial_irq_flag, rx_valid, buffer_full_flag}, 8'h08);
        chk(own_address_reg, 8'h00);
        hold(5);
        // First row runs on the reset mask, so exact match is needed
        foreach (rows[i]) begin
            general_call_enable = rows[i].gce;
            own(rows[i].own);
            if (i > 0) begin
                address_mask_wdata = rows[i].mask;
                pulse(address_mask_wr);
            end
            pulse(serial_irq_clear);
            i2cs_master_model_i.start();
            i2cs_master_model_i.wbyte(rows[i].b, ack);
            hold(8);
            chk({ack, serial_irq_flag}, {6'h00, rows[i].ack, rows[i].ack});
            if (rows[i].ack) begin
                chk({direction_bit, rx_data}, {rows[i].b[0], rows[i].b});
                pulse(rx_ready);
            end
            i2cs_master_model_i.stop();
        end
        // Event mode: start and stop raise the flag
        port_mode_select = 2'b10;
        pulse(serial_irq_clear);
        i2cs_master_model_i.start();
        hold(6);
        chk({start_seen, serial_irq_flag}, 8'h03);
        pulse(serial_irq_clear);
        i2cs_master_model_i.stop();
        hold(6);
        chk({stop_seen, serial_irq_flag}, 8'h03);
        // Fill the buffer with drain stalled, then get refused
        port_mode_select = 2'b00;
        general_call_enable = 1'b0;
        i2cs_master_model_i.start();
        for (int i = 0; i <= 16; i++) begin
            i2cs_master_model_i.wbyte((i == 0) ? 8'ha0 : 8'h0f + 8'(i), ack);
            chk(ack, 8'h01);
        end
        i2cs_master_model_i.stop();
        chk(buffer_full_flag, 8'h01);
        i2cs_master_model_i.start();
        i2cs_master_model_i.wbyte(8'ha0, ack);
        hold(4);
        chk({ack, receive_overflow_flag}, 8'h01);
        i2cs_master_model_i.stop();
        for (int i = 0; i <= 16; i++) begin
            chk({rx_valid, rx_data}, {8'h01, (i == 0) ? 8'ha0 : 8'h0f + 8'(i)});
            pulse(rx_ready);
            hold(1);
            chk(buffer_full_flag, 8'h00);
        end
        chk(rx_valid, 8'h00);
        pulse(overflow_clear);
        // Stretch after a byte until the release bit is set
        stretch_enable = 1'b1;
        i2cs_master_model_i.start();
        i2cs_master_model_i.wbyte(8'ha0, ack);
        hold(8);
        chk({scl_oe, clock_release_bit}, 8'h02);
        pulse(clock_release_set);
        hold(4);
        chk(scl_oe, 8'h00);
        pulse(rx_ready);
        i2cs_master_model_i.stop();
        stretch_enable = 1'b0;
        // Long address: high byte, update handshake, low byte
        port_mode_select = 2'b01;
        own(8'h06);
        pulse(serial_irq_clear);
        i2cs_master_model_i.start();
        i2cs_master_model_i.wbyte(8'hf6, ack);
        hold(8);
        chk({ack, address_update_flag, scl_oe}, 8'h07);
        own(8'h3c);
        hold(1);
        chk(address_update_flag, 8'h00);
        pulse(clock_release_set);
        pulse(serial_irq_clear);
        i2cs_master_model_i.wbyte(8'h3c, ack);
        hold(8);
        chk({ack, address_update_flag, serial_irq_flag, scl_oe}, 8'h0f);
        own(8'h06);
        pulse(clock_release_set);
        i2cs_master_model_i.stop();
        test_done();
    end
endmodule
